// ===== hw/capest_pkg.sv
// constants and types shared by the capacity estimation control block
package capest_pkg;

  // ----------------------------------------
  // register port indices
  // ----------------------------------------
  localparam logic [3:0] IDX_SENSE = 4'h0;
  localparam logic [3:0] IDX_FULL_V = 4'h1;
  localparam logic [3:0] IDX_TAPER_I = 4'h2;
  localparam logic [3:0] IDX_EMPTY_V = 4'h3;
  localparam logic [3:0] IDX_EMPTY_I = 4'h4;
  localparam logic [3:0] IDX_WEAR_LO = 4'h5;
  localparam logic [3:0] IDX_WEAR_HI = 4'h6;
  localparam logic [3:0] IDX_AGE = 4'h7;
  localparam logic [3:0] IDX_STATUS = 4'h8;

  // status byte bit positions
  localparam int STAT_DONE_BIT = 7;
  localparam int STAT_WARN_BIT = 6;
  localparam int STAT_LEARN_BIT = 4;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_SENSE = 8'h00;
  localparam logic [7:0] RST_FULL_V = 8'h00;
  localparam logic [7:0] RST_TAPER_I = 8'h00;
  localparam logic [7:0] RST_EMPTY_V = 8'h00;
  localparam logic [7:0] RST_EMPTY_I = 8'h00;
  localparam logic [15:0] RST_WEAR = 16'h0000;

  // ----------------------------------------
  // age scale codes and aging
  // ----------------------------------------
  localparam logic [7:0] AGE_UNAGED = 8'h80;
  localparam logic [7:0] AGE_FLOOR = 8'h40;
  localparam int AGE_FRAC_BITS = 7;
  localparam int WEAR_MULT_SHIFT = 5;

  // ----------------------------------------
  // measurement scaling
  // ----------------------------------------
  // voltage reading lsb is a quarter of the 19.5 mv limit lsb
  localparam int VOLT_SHIFT = 2;
  // current lsb 1.5625 uv: taper lsb 50 uv = 32x, empty lsb 200 uv = 128x
  localparam int TAPER_SHIFT = 5;
  localparam int EMPTY_I_SHIFT = 7;
  localparam logic [15:0] MEAN_CURRENT_READING_MIN_LSB = 16'h0010;
  localparam logic [7:0] DONE_CLEAR_PCT = 8'h5a;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam longint CLK_HZ = 40000000;
  localparam longint UPDATE_PERIOD_MS = 3500;
  localparam int UPDATE_CYCLES = int'((UPDATE_PERIOD_MS * CLK_HZ) / 1000);

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] sense_conductance;
    logic [7:0] full_voltage_limit;
    logic [7:0] taper_current_limit;
    logic [7:0] empty_voltage_limit;
    logic [7:0] empty_current_limit;
    logic [15:0] wear_rate_charge;
    logic [7:0] age_scale;
  } params_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEARCH = 3'b010,
    ST_LOAD = 3'b100
  } fix_state_t;

endpackage

// ===== hw/capacity_estimation_control.sv
// capacity estimation control: parameters, full/empty detection, learn, aging, coulomb count fixes
//
// Summary of operation
// - hold 8-bit sense conductance for result scaling
// - 8-bit full voltage limit, 19.5 mV steps
// - 8-bit taper current limit, 50 uV steps
// - empty voltage limit compared with mean cell voltage
// - empty current limit is unsigned discharge magnitude
// - 16-bit wear rate charge sets aging speed
// - age scale 2^-7 lsb, 0x80 is unaged
// - age scale never decremented below 0x40
// - host access age scale; auto save and restore
// - aging counter reaching 32x wear charge decrements scale
// - aging counter cleared when learn cycle completes
// - active-empty point sets learn flag
// - learn valid only with uninterrupted charge to full
// - full in learn: clear learn, set done, rescale
// - done sets coulomb count to scaled full lookup
// - rescale age first, then correct coulomb count
// - warning without learn lowers count only if above
// - learn at empty point loads empty model value
// - full needs voltage high across two taper readings
// - both readings positive and above 16 lsb
// - empty point: low voltage after two heavy discharges
// - done flag cleared below 90 percent remaining
// - warning flag set by voltage crossing only
// - capacity results updated every 3.5 seconds
`timescale 1ns/10ps
module capacity_estimation_control
  import capest_pkg::*;
#(
  parameter int UPDATE_COUNT = capest_pkg::UPDATE_CYCLES
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic nv_load,
  input wire capest_pkg::params_t nv_params,
  output logic age_save,
  output logic [7:0] age_save_value,
  input wire logic [15:0] cell_one_voltage,
  input wire logic [15:0] cell_two_voltage,
  input wire logic volt_valid,
  input wire logic signed [15:0] current_reading,
  input wire logic cur_valid,
  input wire logic signed [15:0] mean_current_reading,
  input wire logic mean_current_reading_valid,
  input wire logic [15:0] coulomb_count_register,
  input wire logic [15:0] full_lookup,
  input wire logic [15:0] empty_lookup,
  input wire logic [7:0] remaining_active_percent,
  output logic acr_load,
  output logic [15:0] acr_load_value,
  output logic update_tick,
  output logic learn_flag,
  output logic charge_done_flag,
  output logic empty_warning_flag,
  output logic [7:0] sense_conductance,
  output logic [7:0] age_scale
);
  import capest_pkg::*;

  generate
    if (UPDATE_COUNT < 2)
    begin : g_bad_count
      $error("UPDATE_COUNT must be at least 2");
    end
  endgenerate

  // ----------------------------------------
  // parameter registers
  // ----------------------------------------
  params_t prm_r;
  logic [31:0] upd_cnt_r;
  logic [16:0] mean_v;
  logic volt_above_full;
  logic volt_below_empty;
  logic mean_current_reading_taper_ok;
  logic cur_heavy_disch;
  logic full_detect;
  logic empty_point;
  logic [21:0] age_cnt_r;
  logic [15:0] acr_prev_r;
  logic [21:0] age_threshold;
  logic age_hit;
  logic learn_done;
  fix_state_t st_r;
  logic [7:0] quot_r;
  logic [2:0] bit_r;
  logic [7:0] trial;
  logic [23:0] trial_prod;
  logic [22:0] acr_scaled;
  logic [23:0] full_prod;
  logic [16:0] full_scaled;
  logic full_q_r;
  logic volt_held_r;
  logic [1:0] disch_hist_r;
  logic charging_r;
  logic [7:0] age_prev_r;

  function automatic logic hw_age_write(input logic wr, input logic [3:0] addr);
    hw_age_write = wr && (addr == IDX_AGE);
  endfunction

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prm_r <= '{RST_SENSE, RST_FULL_V, RST_TAPER_I, RST_EMPTY_V, RST_EMPTY_I, RST_WEAR, AGE_UNAGED};
    end
    else if (nv_load)
    begin
      prm_r <= nv_params;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        IDX_SENSE: prm_r.sense_conductance <= reg_wdata;
        IDX_FULL_V: prm_r.full_voltage_limit <= reg_wdata;
        IDX_TAPER_I: prm_r.taper_current_limit <= reg_wdata;
        IDX_EMPTY_V: prm_r.empty_voltage_limit <= reg_wdata;
        IDX_EMPTY_I: prm_r.empty_current_limit <= reg_wdata;
        IDX_WEAR_LO: prm_r.wear_rate_charge[7:0] <= reg_wdata;
        IDX_WEAR_HI: prm_r.wear_rate_charge[15:8] <= reg_wdata;
        default: prm_r <= prm_r;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 8'h00;
    end
    else
    begin
      case (reg_addr)
        IDX_SENSE: reg_rdata <= prm_r.sense_conductance;
        IDX_FULL_V: reg_rdata <= prm_r.full_voltage_limit;
        IDX_TAPER_I: reg_rdata <= prm_r.taper_current_limit;
        IDX_EMPTY_V: reg_rdata <= prm_r.empty_voltage_limit;
        IDX_EMPTY_I: reg_rdata <= prm_r.empty_current_limit;
        IDX_WEAR_LO: reg_rdata <= prm_r.wear_rate_charge[7:0];
        IDX_WEAR_HI: reg_rdata <= prm_r.wear_rate_charge[15:8];
        IDX_AGE: reg_rdata <= age_scale;
        IDX_STATUS:
        begin
          reg_rdata <= 8'h00;
          reg_rdata[STAT_DONE_BIT] <= charge_done_flag;
          reg_rdata[STAT_WARN_BIT] <= empty_warning_flag;
          reg_rdata[STAT_LEARN_BIT] <= learn_flag;
        end
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  assign sense_conductance = prm_r.sense_conductance;

  // ----------------------------------------
  // result update interval
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      upd_cnt_r <= 32'h0;
      update_tick <= 1'b0;
    end
    else
    begin
      update_tick <= (upd_cnt_r == 32'(UPDATE_COUNT - 1));
      upd_cnt_r <= (upd_cnt_r == 32'(UPDATE_COUNT - 1)) ? 32'h0 : upd_cnt_r + 32'h1;
    end
  end

  // ----------------------------------------
  // threshold comparisons
  // ----------------------------------------
  // mean of the two cells, never either cell alone
  assign mean_v = ({1'b0, cell_one_voltage} + {1'b0, cell_two_voltage}) >> 1;
  assign volt_above_full = mean_v > {7'h0, prm_r.full_voltage_limit, 2'b00};
  assign volt_below_empty = mean_v < {7'h0, prm_r.empty_voltage_limit, 2'b00};
  assign mean_current_reading_taper_ok = (mean_current_reading > $signed(MEAN_CURRENT_READING_MIN_LSB))
    && (mean_current_reading < $signed({3'b000, prm_r.taper_current_limit, 5'b00000}));
  assign cur_heavy_disch = (current_reading < 16'sh0000)
    && (current_reading < -$signed({1'b0, prm_r.empty_current_limit, 7'h00}));

  // ----------------------------------------
  // full detection
  // ----------------------------------------
  // voltage must hold through the whole span between the two readings
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      full_q_r <= 1'b0;
      volt_held_r <= 1'b0;
    end
    else
    begin
      if (mean_current_reading_valid)
      begin
        full_q_r <= mean_current_reading_taper_ok && volt_above_full;
        volt_held_r <= volt_above_full;
      end
      else if (volt_valid && !volt_above_full)
      begin
        volt_held_r <= 1'b0;
      end
    end
  end

  assign full_detect = mean_current_reading_valid && mean_current_reading_taper_ok && full_q_r && volt_held_r && volt_above_full;

  // ----------------------------------------
  // active-empty point detection
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      disch_hist_r <= 2'b00;
    end
    else if (cur_valid)
    begin
      disch_hist_r <= {disch_hist_r[0], cur_heavy_disch};
    end
  end

  assign empty_point = volt_valid && volt_below_empty && (&disch_hist_r);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      empty_warning_flag <= 1'b0;
    end
    else if (volt_valid)
    begin
      empty_warning_flag <= volt_below_empty;
    end
  end

  // ----------------------------------------
  // learn cycle tracking
  // ----------------------------------------
  assign learn_done = full_detect && learn_flag;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      learn_flag <= 1'b0;
      charging_r <= 1'b0;
    end
    else if (empty_point)
    begin
      learn_flag <= 1'b1;
      charging_r <= 1'b0;
    end
    else if (learn_done)
    begin
      learn_flag <= 1'b0;
      charging_r <= 1'b0;
    end
    else if (learn_flag && mean_current_reading_valid)
    begin
      if (mean_current_reading > 16'sh0000)
      begin
        charging_r <= 1'b1;
      end
      else if (charging_r)
      begin
        learn_flag <= 1'b0;
        charging_r <= 1'b0;
      end
    end
  end

  // set wins over the percent-based clear
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      charge_done_flag <= 1'b0;
    end
    else if (full_detect)
    begin
      charge_done_flag <= 1'b1;
    end
    else if (remaining_active_percent < DONE_CLEAR_PCT)
    begin
      charge_done_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // cycle-count aging
  // ----------------------------------------
  assign age_threshold = {1'b0, prm_r.wear_rate_charge, 5'b00000};
  // a zero wear charge would age on every step, so it disables aging
  assign age_hit = (prm_r.wear_rate_charge != 16'h0) && (age_cnt_r >= age_threshold);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      age_cnt_r <= 22'h0;
      acr_prev_r <= 16'h0;
    end
    else
    begin
      acr_prev_r <= coulomb_count_register;
      if (learn_done)
      begin
        age_cnt_r <= 22'h0;
      end
      else if (age_hit)
      begin
        age_cnt_r <= 22'h0;
      end
      else if (!acr_load && coulomb_count_register < acr_prev_r)
      begin
        age_cnt_r <= age_cnt_r + {6'h0, acr_prev_r - coulomb_count_register};
      end
    end
  end

  // ----------------------------------------
  // learned scale search and count fixes
  // ----------------------------------------
  // bitwise search of scale = count * 128 / full, one multiplier over 8 cycles
  assign trial = quot_r | (8'h01 << bit_r);
  assign trial_prod = full_lookup * trial;
  assign acr_scaled = {coulomb_count_register, 7'h00};
  assign full_prod = full_lookup * age_scale;
  assign full_scaled = full_prod[23:7];

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= ST_IDLE;
      quot_r <= 8'h00;
      bit_r <= 3'h0;
    end
    else
    begin
      case (st_r)
        ST_IDLE:
        begin
          quot_r <= 8'h00;
          bit_r <= 3'h7;
          if (learn_done)
          begin
            st_r <= ST_SEARCH;
          end
          else if (full_detect)
          begin
            st_r <= ST_LOAD;
          end
        end
        ST_SEARCH:
        begin
          if (trial_prod <= {1'b0, acr_scaled})
          begin
            quot_r <= trial;
          end
          bit_r <= bit_r - 3'h1;
          if (bit_r == 3'h0)
          begin
            st_r <= ST_LOAD;
          end
        end
        ST_LOAD: st_r <= ST_IDLE;
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      age_scale <= AGE_UNAGED;
    end
    else if (nv_load)
    begin
      age_scale <= nv_params.age_scale;
    end
    else if (hw_age_write(reg_wr, reg_addr))
    begin
      age_scale <= reg_wdata;
    end
    else if (st_r == ST_SEARCH && bit_r == 3'h0)
    begin
      // final pick; the floor also bounds learned results
      if ((trial_prod <= {1'b0, acr_scaled} ? trial : quot_r) < AGE_FLOOR)
      begin
        age_scale <= AGE_FLOOR;
      end
      else
      begin
        age_scale <= (trial_prod <= {1'b0, acr_scaled}) ? trial : quot_r;
      end
    end
    else if (age_hit && age_scale > AGE_FLOOR)
    begin
      age_scale <= age_scale - 8'h01;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      age_prev_r <= AGE_UNAGED;
      age_save <= 1'b0;
      age_save_value <= AGE_UNAGED;
    end
    else
    begin
      age_prev_r <= age_scale;
      age_save <= (age_scale != age_prev_r);
      age_save_value <= age_scale;
    end
  end

  // full load has priority; empty fixes only while no full fix runs
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acr_load <= 1'b0;
      acr_load_value <= 16'h0000;
    end
    else if (st_r == ST_LOAD)
    begin
      acr_load <= 1'b1;
      acr_load_value <= full_scaled[16] ? 16'hffff : full_scaled[15:0];
    end
    else if (st_r == ST_IDLE && empty_point)
    begin
      acr_load <= 1'b1;
      acr_load_value <= empty_lookup;
    end
    else if (st_r == ST_IDLE && update_tick && empty_warning_flag && !learn_flag
      && coulomb_count_register > empty_lookup)
    begin
      acr_load <= 1'b1;
      acr_load_value <= empty_lookup;
    end
    else
    begin
      acr_load <= 1'b0;
    end
  end

endmodule

// ===== verif/capacity_estimation_control_props.sv
// port level assertions for the capacity estimation control block
`timescale 1ns/10ps
module capacity_estimation_control_props
#(
  parameter int UPDATE_COUNT = 16
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic nv_load,
  input wire capest_pkg::params_t nv_params,
  input wire logic age_save,
  input wire logic [7:0] age_save_value,
  input wire logic [15:0] cell_one_voltage,
  input wire logic [15:0] cell_two_voltage,
  input wire logic volt_valid,
  input wire logic signed [15:0] current_reading,
  input wire logic cur_valid,
  input wire logic signed [15:0] mean_current_reading,
  input wire logic mean_current_reading_valid,
  input wire logic [15:0] coulomb_count_register,
  input wire logic [15:0] full_lookup,
  input wire logic [15:0] empty_lookup,
  input wire logic [7:0] remaining_active_percent,
  input wire logic acr_load,
  input wire logic [15:0] acr_load_value,
  input wire logic update_tick,
  input wire logic learn_flag,
  input wire logic charge_done_flag,
  input wire logic empty_warning_flag,
  input wire logic [7:0] sense_conductance,
  input wire logic [7:0] age_scale
);
  import capest_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  int gap_r;
  logic seen_r;

  function automatic logic [15:0] scaled_full(input logic [15:0] f, input logic [7:0] a);
    logic [23:0] p;
    p = ({8'h00, f} * {16'h0000, a}) >> 7;
    return (p > 24'h00ffff) ? 16'hffff : p[15:0];
  endfunction

  // gap since last tick; first tick only arms the check
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gap_r <= 0;
      seen_r <= 1'b0;
    end
    else if (update_tick)
    begin
      gap_r <= 1;
      seen_r <= 1'b1;
    end
    else
    begin
      gap_r <= gap_r + 1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_tick_gap;
    seen_r && (update_tick || gap_r > UPDATE_COUNT) |-> update_tick && gap_r == UPDATE_COUNT;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("update tick spacing wrong");

  property p_learn_cause;
    $rose(learn_flag) |-> $past(volt_valid) || $past(volt_valid, 2);
  endproperty
  a_learn_cause: assert property (p_learn_cause) else $error("learn flag set without voltage sample");

  property p_learn_load;
    $rose(learn_flag) |-> ##[0:2] (acr_load && acr_load_value == empty_lookup);
  endproperty
  a_learn_load: assert property (p_learn_load) else $error("empty point load missing");

  property p_done_cause;
    $rose(charge_done_flag) |-> $past(mean_current_reading_valid) || $past(mean_current_reading_valid, 2);
  endproperty
  a_done_cause: assert property (p_done_cause) else $error("done flag set without average reading");

  property p_done_load;
    $rose(charge_done_flag) |-> ##[1:10] acr_load;
  endproperty
  a_done_load: assert property (p_done_load) else $error("full load missing after done");

  property p_full_value;
    acr_load && charge_done_flag && !empty_warning_flag && !learn_flag
      |-> acr_load_value == scaled_full(full_lookup, age_scale);
  endproperty
  a_full_value: assert property (p_full_value) else $error("full load value wrong");

  property p_empty_value;
    acr_load && !charge_done_flag |-> acr_load_value == empty_lookup;
  endproperty
  a_empty_value: assert property (p_empty_value) else $error("empty load value wrong");

  property p_fix_above;
    acr_load && !charge_done_flag && !learn_flag |-> $past(coulomb_count_register) > empty_lookup;
  endproperty
  a_fix_above: assert property (p_fix_above) else $error("count raised by warning fix");

  property p_age_floor;
    age_scale == $past(age_scale) - 8'h01 && !$past(reg_wr) && !$past(nv_load) |-> $past(age_scale) > AGE_FLOOR;
  endproperty
  a_age_floor: assert property (p_age_floor) else $error("age scale aged below floor");

  property p_save_write;
    reg_wr && !nv_load && reg_addr == IDX_AGE && reg_wdata != age_scale |-> ##[1:2] age_save;
  endproperty
  a_save_write: assert property (p_save_write) else $error("age save missing after write");

  property p_rdata_age;
    $past(rst_n) && $past(reg_addr) == IDX_AGE && $stable(age_scale) |-> reg_rdata == $past(age_scale);
  endproperty
  a_rdata_age: assert property (p_rdata_age) else $error("age scale read wrong");

  property p_warn_cause;
    $rose(empty_warning_flag) |-> $past(volt_valid) || $past(volt_valid, 2);
  endproperty
  a_warn_cause: assert property (p_warn_cause) else $error("warning set without voltage sample");
endmodule

bind capacity_estimation_control capacity_estimation_control_props #(.UPDATE_COUNT(UPDATE_COUNT)) u_props (.*);

// ===== verif/capacity_estimation_control_test.sv
// self-checking bench for the capacity estimation control block
`timescale 1ns/10ps
module capacity_estimation_control_test;
  import capest_pkg::*;
  localparam int UPD = 16;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic nv_load = 1'b0;
  params_t nv_params = '0;
  logic age_save;
  logic [7:0] age_save_value;
  logic [15:0] cell_one_voltage = 16'h0300;
  logic [15:0] cell_two_voltage = 16'h0300;
  logic volt_valid = 1'b0;
  logic signed [15:0] current_reading = 16'sh0000;
  logic cur_valid = 1'b0;
  logic signed [15:0] mean_current_reading = 16'sh0000;
  logic mean_current_reading_valid = 1'b0;
  logic [15:0] coulomb_count_register = 16'h0800;
  logic [15:0] full_lookup = 16'h4000;
  logic [15:0] empty_lookup = 16'h0400;
  logic [7:0] remaining_active_percent = 8'h64;
  logic acr_load;
  logic [15:0] acr_load_value;
  logic update_tick;
  logic learn_flag;
  logic charge_done_flag;
  logic empty_warning_flag;
  logic [7:0] sense_conductance;
  logic [7:0] age_scale;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;
  params_t sh;
  logic [15:0] seen_v;
  logic got;
  int dn [4] = '{32, 31, 1, 64};
  logic [7:0] ea [4] = '{8'h41, 8'h41, 8'h40, 8'h40};

  always #12.5 core_clk = ~core_clk;

  capacity_estimation_control #(.UPDATE_COUNT(UPD)) DUT (.*);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      results();
    end
  end

  function automatic logic [7:0] regbyte(input params_t p, input int i);
    logic [63:0] b;
    b = p;
    case (i)
      5: return b[15:8];
      6: return b[23:16];
      7: return b[7:0];
      default: return b[63 - 8 * i -: 8];
    endcase
  endfunction

  function automatic logic [7:0] learned(input logic [15:0] c, input logic [15:0] f);
    logic [31:0] q;
    q = ({16'h0000, c} << 7) / {16'h0000, f};
    return (q < 32'h40) ? 8'h40 : (q > 32'hff) ? 8'hff : q[7:0];
  endfunction

  function automatic logic [15:0] full_fix(input logic [15:0] f, input logic [7:0] a);
    logic [23:0] p;
    p = ({8'h00, f} * {16'h0000, a}) >> 7;
    return (p > 24'h00ffff) ? 16'hffff : p[15:0];
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    reg_addr = a;
    cyc(1);
    chk("reg_rdata", 16'(reg_rdata), 16'(exp));
  endtask

  task automatic volt(input logic [15:0] a, input logic [15:0] b);
    cyc(1);
    cell_one_voltage = a;
    cell_two_voltage = b;
    volt_valid = 1'b1;
    cyc(1);
    volt_valid = 1'b0;
  endtask

  task automatic cur(input logic signed [15:0] i);
    cyc(1);
    current_reading = i;
    cur_valid = 1'b1;
    cyc(1);
    cur_valid = 1'b0;
  endtask

  task automatic avg(input logic signed [15:0] i);
    cyc(1);
    mean_current_reading = i;
    mean_current_reading_valid = 1'b1;
    cyc(1);
    mean_current_reading_valid = 1'b0;
  endtask

  // one-cycle load pulse: look before each advance
  task automatic wait_load(input int n);
    got = 1'b0;
    seen_v = 16'hxxxx;
    for (int k = 0; k < n && !got; k++)
    begin
      if (acr_load === 1'b1)
      begin
        got = 1'b1;
        seen_v = acr_load_value;
        cyc(1);
      end
      else
        cyc(1);
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'h95c7d6e4));
    cyc(8);
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) rd(4'(i), (i == 7) ? AGE_UNAGED : 8'h00);
    sh = {$urandom, $urandom};
    for (int i = 0; i < 8; i++) wr(4'(i), regbyte(sh, i));
    for (int i = 0; i < 8; i++) rd(4'(i), regbyte(sh, i));
    wr(IDX_AGE, 8'h60);
    for (int k = 0; k < 4 && age_save !== 1'b1; k++) cyc(1);
    chk("age_save", 16'(age_save), 16'h0001);
    chk("age_save_value", 16'(age_save_value), 16'h0060);
    wr(IDX_STATUS, 8'hff);
    rd(IDX_STATUS, 8'h00);
    rd(4'h9, 8'h00);
    // power-up restore wins over a clashing host write
    nv_params = {$urandom, $urandom};
    reg_wr = 1'b1;
    reg_addr = IDX_SENSE;
    reg_wdata = ~nv_params.sense_conductance;
    nv_load = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    nv_load = 1'b0;
    for (int i = 0; i < 8; i++) rd(4'(i), regbyte(nv_params, i));
    chk("sense_conductance", 16'(sense_conductance), 16'(nv_params.sense_conductance));
    sh = {8'h32, 8'h40, 8'h10, 8'h80, 8'h01, 16'h0000, 8'h80};
    for (int i = 0; i < 8; i++) wr(4'(i), regbyte(sh, i));
    // mean below limit though one cell is above; light second reading
    cur(-16'sh0100);
    cur(-16'sh0010);
    volt(16'h0100, 16'h02f0);
    cyc(2);
    chk("learn_flag", 16'(learn_flag), 16'h0000);
    chk("empty_warning_flag", 16'(empty_warning_flag), 16'h0001);
    wait_load(UPD + 4);
    chk("warn fix", seen_v, empty_lookup);
    coulomb_count_register = 16'h0300;
    wait_load(2 * UPD + 4);
    chk("warn fix below", 16'(got), 16'h0000);
    cur(-16'sh0100);
    cur(-16'sh0100);
    volt(16'h0100, 16'h02f0);
    wait_load(4);
    chk("empty point load", seen_v, empty_lookup);
    chk("learn_flag", 16'(learn_flag), 16'h0001);
    avg(16'sh0100);
    avg(-16'sh0020);
    cyc(2);
    chk("learn abandoned", {learn_flag, age_scale}, {1'b0, 8'h80});
    cur(-16'sh0100);
    cur(-16'sh0100);
    volt(16'h0100, 16'h02f0);
    cyc(3);
    coulomb_count_register = 16'h3000;
    volt(16'h0200, 16'h0200);
    avg(16'sh0100);
    avg(16'sh0100);
    wait_load(20);
    chk("learned age", 16'(age_scale), 16'(learned(16'h3000, full_lookup)));
    chk("learned load", seen_v, full_fix(full_lookup, learned(16'h3000, full_lookup)));
    chk("flags", {learn_flag, charge_done_flag}, 16'h0001);
    remaining_active_percent = 8'h59;
    for (int k = 0; k < 40 && charge_done_flag !== 1'b0; k++) cyc(1);
    chk("charge_done_flag", 16'(charge_done_flag), 16'h0000);
    remaining_active_percent = 8'h64;
    avg(16'sh0010);
    avg(16'sh0010);
    avg(16'sh0200);
    avg(16'sh0200);
    cyc(3);
    chk("no full", 16'(charge_done_flag), 16'h0000);
    full_lookup = 16'h8000 | 16'($urandom);
    avg(16'sh0011);
    avg(16'sh0011);
    wait_load(6);
    chk("full load", seen_v, full_fix(full_lookup, learned(16'h3000, 16'h4000)));
    // aging: one count per cycle so the threshold is met exactly
    wr(IDX_WEAR_LO, 8'h01);
    wr(IDX_AGE, 8'h42);
    for (int s = 0; s < 4; s++)
    begin
      repeat (dn[s])
      begin
        coulomb_count_register = coulomb_count_register - 16'h0001;
        cyc(1);
      end
      cyc(2);
      chk("aged scale", 16'(age_scale), 16'(ea[s]));
    end
    results();
  end
endmodule
